/* File: rdc_defs.vh */
// Constants for the redriver strap and receiver-detect control block
`ifndef RDC_DEFS_VH
`define RDC_DEFS_VH

// Four-level strap codes
`define RDC_LVL_L0 2'h0
`define RDC_LVL_L1 2'h1
`define RDC_LVL_L2 2'h2
`define RDC_LVL_L3 2'h3

// Cycles after reset release before straps are captured
`define RDC_STRAP_WAIT 2'h3

// Wishbone register byte offsets
`define RDC_REG_CTRL 8'h00
`define RDC_REG_EQ 8'h04
`define RDC_REG_STATUS 8'h08
`define RDC_REG_STRAP 8'h0c
`define RDC_CTRL_TRIG_BIT 0
`define RDC_EQ_RESET 16'h0000

// Serial target
`define RDC_TGT_ADDR_BASE 7'h18
`define RDC_TGT_IDX_TRIG 8'h04

// DC gain codes
`define RDC_GAIN_P3_5 3'h0
`define RDC_GAIN_0 3'h1
`define RDC_GAIN_M1_5 3'h2
`define RDC_GAIN_M3_5 3'h3
`define RDC_GAIN_M6 3'h4

// Detection probe interval
`define RDC_CLK_PERIOD_NS 20
`define RDC_PROBE_NS 10000
`define RDC_PROBE_CYC (`RDC_PROBE_NS / `RDC_CLK_PERIOD_NS)
// Last divider count, probe cycles minus one
`define RDC_PROBE_LAST 9'h1f3

// Detection state codes
`define RDC_DET_IDLE 2'h0
`define RDC_DET_PROBE 2'h1
`define RDC_DET_DONE 2'h2

`endif

/* File: rdc_strap_latch.v */
// Four-level strap synchroniser and capture after reset
`timescale 1ns/1ps
`include "rdc_defs.vh"
module rdc_strap_latch (
	input wire clk_i,
	input wire rst_i,
	input wire [1:0] level_i,
	output reg [1:0] level_o,
	output reg captured_o
);
	reg [1:0] sync1;
	reg [1:0] sync2;
	reg [1:0] wait_cnt;

	always @(posedge clk_i) begin
		sync1 <= level_i;
		sync2 <= sync1;
	end

	// Capture once, then hold for the rest of operation
	always @(posedge clk_i) begin
		if (rst_i) begin
			wait_cnt <= 2'h0;
			captured_o <= 1'b0;
			level_o <= `RDC_LVL_L2;
		end else if (!captured_o) begin
			if (wait_cnt == `RDC_STRAP_WAIT) begin
				level_o <= sync2;
				captured_o <= 1'b1;
			end else begin
				wait_cnt <= wait_cnt + 2'h1;
			end
		end
	end
endmodule

/* File: rdc_rx_detect.v */
// Per-channel receiver-detect state machine and termination control
`timescale 1ns/1ps
`include "rdc_defs.vh"
module rdc_rx_detect (
	input wire clk_i,
	input wire rst_i,
	input wire standby_i,
	input wire bypass_i,
	input wire [1:0] need_i,
	input wire start_i,
	input wire tick_i,
	input wire present_i,
	output wire term_50_o,
	output wire detected_o
);
	reg [1:0] state;
	reg [1:0] count;

	always @(posedge clk_i) begin
		if (rst_i || standby_i || bypass_i) begin
			state <= `RDC_DET_IDLE;
			count <= 2'h0;
		end else begin
			case (state)
				`RDC_DET_IDLE: begin
					if (start_i) begin
						state <= `RDC_DET_PROBE;
						count <= 2'h0;
					end
				end
				`RDC_DET_PROBE: begin
					if (tick_i) begin
						if (present_i) begin
							if (count + 2'h1 == need_i) begin
								state <= `RDC_DET_DONE;
							end
							count <= count + 2'h1;
						end else begin
							count <= 2'h0;
						end
					end
				end
				`RDC_DET_DONE: begin
					if (start_i) begin
						state <= `RDC_DET_PROBE;
						count <= 2'h0;
					end
				end
				default: begin
					state <= `RDC_DET_IDLE;
				end
			endcase
		end
	end

	// Hi-Z before detection, 50 ohm after; bypass 50 ohm outside standby
	assign term_50_o = !standby_i && (bypass_i || state == `RDC_DET_DONE);
	assign detected_o = !standby_i && !bypass_i && state == `RDC_DET_DONE;
endmodule

/* File: rdc_ctrl.v */
// Redriver strap decode, serial target, Wishbone registers and detect control
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "rdc_defs.vh"
// Functional notes
// - Each of four channels has its own EQ index and detect state; DC gain is shared.
// - Strap mode at select L0: EQ index is high strap times four plus low.
// - Strap DC gain: L3/L2 +3.5, L2 with swing L2/L3/L1/L0 0/-1.5/-3.5/-6 dB.
// - Gain and swing straps both floating give 0 dB.
// - Detection starts at power-up, standby release in strap mode, software trigger in target mode.
// - Detected after 2, 3 or 1 valid detections for detect strap L0, L1, L2.
// - Termination is high impedance until detected, then 50 ohm.
// - Detect strap L3 disables detection; termination is 50 ohm outside standby.
// - Standby pin high resets detection and makes termination high impedance.
// - Standby pin high puts channels in standby; low resumes operation.
// - First standby pin serves channels 1-2, second serves channels 3-4.
// - Each six four-level strap decodes to levels L0 to L3.
// - Target mode takes equalization from serial-bus registers.
// - Select L3: serial target at address 0x18 plus four high plus low.
module rdc_ctrl (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [1:0] gain_strap_i,
	input wire [1:0] output_swing_strap_i,
	input wire [1:0] eq_high_strap_i,
	input wire [1:0] eq_low_strap_i,
	input wire [1:0] control_interface_select_i,
	input wire [1:0] detect_config_strap_i,
	input wire standby_pin_pair_a_i,
	input wire standby_pin_pair_b_i,
	input wire [3:0] rx_present_i,
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output reg sda_oe_o,
	output reg [15:0] eq_index_o,
	output reg [2:0] dc_gain_o,
	output wire [3:0] term_50_o,
	output wire [3:0] rx_detected_o,
	output reg [3:0] standby_o
);
	wire [1:0] gain_lvl;
	wire [1:0] swing_lvl;
	wire [1:0] eqh_lvl;
	wire [1:0] eql_lvl;
	wire [1:0] sel_lvl;
	wire [1:0] det_lvl;
	wire [5:0] cap;
	wire straps_ready;
	reg ready_d;
	wire pwrup_start;
	wire strap_mode;
	wire target_mode;
	wire [3:0] strap_eq;
	wire [6:0] tgt_addr;
	reg [1:0] need;
	wire bypass;
	reg [1:0] pwdn_s1;
	reg [1:0] pwdn_s2;
	reg [1:0] pwdn_d;
	wire [1:0] pwdn_fall;
	reg [3:0] pres_s1;
	reg [3:0] pres_s2;
	reg [8:0] tick_cnt;
	reg tick;
	reg [15:0] eq_reg;
	wire wb_req;
	wire wb_wr;
	wire sw_trig;
	wire [3:0] start;
	wire [3:0] chan_standby;
	reg [31:0] next_rdata;
	reg scl_s1;
	reg scl_s2;
	reg scl_d;
	reg sda_s1;
	reg sda_s2;
	reg sda_d;
	wire scl_rise;
	wire scl_fall;
	wire i2c_start;
	wire i2c_stop;
	reg i2c_busy;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	reg [1:0] byte_cnt;
	reg addr_ok;
	reg [7:0] i2c_idx;
	reg i2c_wr;
	reg [7:0] i2c_wdata;
	reg [7:0] i2c_widx;
	genvar gi;

	// Strap capture
	rdc_strap_latch u_gain (.clk_i(clk_i), .rst_i(rst_i), .level_i(gain_strap_i), .level_o(gain_lvl),
		.captured_o(cap[0]));
	rdc_strap_latch u_swing (.clk_i(clk_i), .rst_i(rst_i), .level_i(output_swing_strap_i),
		.level_o(swing_lvl), .captured_o(cap[1]));
	rdc_strap_latch u_eqh (.clk_i(clk_i), .rst_i(rst_i), .level_i(eq_high_strap_i), .level_o(eqh_lvl),
		.captured_o(cap[2]));
	rdc_strap_latch u_eql (.clk_i(clk_i), .rst_i(rst_i), .level_i(eq_low_strap_i), .level_o(eql_lvl),
		.captured_o(cap[3]));
	rdc_strap_latch u_sel (.clk_i(clk_i), .rst_i(rst_i), .level_i(control_interface_select_i),
		.level_o(sel_lvl), .captured_o(cap[4]));
	rdc_strap_latch u_det (.clk_i(clk_i), .rst_i(rst_i), .level_i(detect_config_strap_i),
		.level_o(det_lvl), .captured_o(cap[5]));

	assign straps_ready = &cap;
	assign strap_mode = straps_ready && sel_lvl == `RDC_LVL_L0;
	assign target_mode = straps_ready && sel_lvl == `RDC_LVL_L3;
	assign strap_eq = {eqh_lvl, eql_lvl};
	assign tgt_addr = `RDC_TGT_ADDR_BASE + {3'h0, eqh_lvl, 2'h0} + {5'h00, eql_lvl};
	assign bypass = det_lvl == `RDC_LVL_L3;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ready_d <= 1'b0;
		end else begin
			ready_d <= straps_ready;
		end
	end
	assign pwrup_start = straps_ready && !ready_d;

	// Confirmation count from detect strap
	always @* begin
		case (det_lvl)
			`RDC_LVL_L0: need = 2'h2;
			`RDC_LVL_L1: need = 2'h3;
			default: need = 2'h1;
		endcase
	end

	// DC gain decode
	always @(posedge clk_i) begin
		if (rst_i) begin
			dc_gain_o <= `RDC_GAIN_0;
		end else if (gain_lvl == `RDC_LVL_L3 && swing_lvl == `RDC_LVL_L2) begin
			dc_gain_o <= `RDC_GAIN_P3_5;
		end else if (gain_lvl == `RDC_LVL_L2) begin
			case (swing_lvl)
				`RDC_LVL_L3: dc_gain_o <= `RDC_GAIN_M1_5;
				`RDC_LVL_L1: dc_gain_o <= `RDC_GAIN_M3_5;
				`RDC_LVL_L0: dc_gain_o <= `RDC_GAIN_M6;
				default: dc_gain_o <= `RDC_GAIN_0;
			endcase
		end else begin
			dc_gain_o <= `RDC_GAIN_0;
		end
	end

	// Standby pins and far-end presence synchronisers
	always @(posedge clk_i) begin
		pwdn_s1 <= {standby_pin_pair_b_i, standby_pin_pair_a_i};
		pwdn_s2 <= pwdn_s1;
		pres_s1 <= rx_present_i;
		pres_s2 <= pres_s1;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			pwdn_d <= 2'h0;
			standby_o <= 4'h0;
		end else begin
			pwdn_d <= pwdn_s2;
			standby_o <= {pwdn_s2[1], pwdn_s2[1], pwdn_s2[0], pwdn_s2[0]};
		end
	end
	assign pwdn_fall = pwdn_d & ~pwdn_s2;
	assign chan_standby = {pwdn_s2[1], pwdn_s2[1], pwdn_s2[0], pwdn_s2[0]};

	// Probe interval divider
	always @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt <= 9'h000;
			tick <= 1'b0;
		end else if (tick_cnt == `RDC_PROBE_LAST) begin
			tick_cnt <= 9'h000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 9'h001;
			tick <= 1'b0;
		end
	end

	// Detection start per channel pair
	assign start[1:0] = {2{pwrup_start || (strap_mode && pwdn_fall[0]) || (target_mode && sw_trig)}};
	assign start[3:2] = {2{pwrup_start || (strap_mode && pwdn_fall[1]) || (target_mode && sw_trig)}};

	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
			rdc_rx_detect u_det (
				.clk_i(clk_i),
				.rst_i(rst_i || !straps_ready),
				.standby_i(chan_standby[gi]),
				.bypass_i(bypass),
				.need_i(need),
				.start_i(start[gi]),
				.tick_i(tick),
				.present_i(pres_s2[gi]),
				.term_50_o(term_50_o[gi]),
				.detected_o(rx_detected_o[gi])
			);
		end
	endgenerate

	// Wishbone slave
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	assign sw_trig = (wb_wr && wb_adr_i == `RDC_REG_CTRL && wb_sel_i[0] && wb_dat_i[`RDC_CTRL_TRIG_BIT]) ||
		(i2c_wr && i2c_widx == `RDC_TGT_IDX_TRIG && i2c_wdata[0]);

	always @* begin
		next_rdata = 32'h00000000;
		case (wb_adr_i)
			`RDC_REG_EQ: next_rdata = {16'h0000, eq_reg};
			`RDC_REG_STATUS: next_rdata = {16'h0000, standby_o, 2'h0, target_mode, strap_mode, term_50_o,
				rx_detected_o};
			`RDC_REG_STRAP: next_rdata = {19'h00000, straps_ready, det_lvl, sel_lvl, eqh_lvl, eql_lvl, swing_lvl,
				gain_lvl};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : 32'h00000000;
		end
	end

	// Equalization registers, serial target takes priority
	always @(posedge clk_i) begin
		if (rst_i) begin
			eq_reg <= `RDC_EQ_RESET;
		end else if (i2c_wr && i2c_widx < 8'h04) begin
			eq_reg[i2c_widx[1:0] * 4 +: 4] <= i2c_wdata[3:0];
		end else if (wb_wr && wb_adr_i == `RDC_REG_EQ) begin
			if (wb_sel_i[0]) begin
				eq_reg[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				eq_reg[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			eq_index_o <= 16'h0000;
		end else if (target_mode) begin
			eq_index_o <= eq_reg;
		end else begin
			eq_index_o <= {4{strap_eq}};
		end
	end

	// Serial target, write only
	always @(posedge clk_i) begin
		scl_s1 <= scl_i;
		scl_s2 <= scl_s1;
		sda_s1 <= sda_i;
		sda_s2 <= sda_s1;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s2;
			sda_d <= sda_s2;
		end
	end

	assign scl_rise = scl_s2 && !scl_d;
	assign scl_fall = !scl_s2 && scl_d;
	assign i2c_start = scl_s2 && scl_d && sda_d && !sda_s2;
	assign i2c_stop = scl_s2 && scl_d && !sda_d && sda_s2;
	assign sda_o = 1'b0;

	always @(posedge clk_i) begin
		if (rst_i || !target_mode) begin
			i2c_busy <= 1'b0;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			byte_cnt <= 2'h0;
			addr_ok <= 1'b0;
			i2c_idx <= 8'h00;
			i2c_wr <= 1'b0;
			i2c_wdata <= 8'h00;
			i2c_widx <= 8'h00;
			sda_oe_o <= 1'b0;
		end else begin
			i2c_wr <= 1'b0;
			if (i2c_start) begin
				i2c_busy <= 1'b1;
				bit_cnt <= 4'h0;
				byte_cnt <= 2'h0;
				addr_ok <= 1'b0;
				sda_oe_o <= 1'b0;
			end else if (i2c_stop) begin
				i2c_busy <= 1'b0;
				sda_oe_o <= 1'b0;
			end else if (i2c_busy && scl_rise && bit_cnt < 4'h8) begin
				shreg <= {shreg[6:0], sda_s2};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (i2c_busy && scl_fall && bit_cnt == 4'h8) begin
				bit_cnt <= 4'h9;
				if (byte_cnt == 2'h0) begin
					addr_ok <= shreg[7:1] == tgt_addr && !shreg[0];
					sda_oe_o <= shreg[7:1] == tgt_addr && !shreg[0];
					byte_cnt <= 2'h1;
				end else if (addr_ok) begin
					sda_oe_o <= 1'b1;
					if (byte_cnt == 2'h1) begin
						i2c_idx <= shreg;
						byte_cnt <= 2'h2;
					end else begin
						i2c_wr <= 1'b1;
						i2c_wdata <= shreg;
						i2c_widx <= i2c_idx;
						i2c_idx <= i2c_idx + 8'h01;
					end
				end
			end else if (i2c_busy && scl_fall && bit_cnt == 4'h9) begin
				sda_oe_o <= 1'b0;
				bit_cnt <= 4'h0;
				if (!addr_ok) begin
					i2c_busy <= 1'b0;
				end
			end
		end
	end
endmodule

/* File: rdc_ctrl_props.sv */
// Concurrent checks on the redriver control block ports
`timescale 1ns/1ps
module rdc_ctrl_chk (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire [1:0] gain_strap_i,
	input wire [1:0] output_swing_strap_i,
	input wire [1:0] eq_high_strap_i,
	input wire [1:0] eq_low_strap_i,
	input wire [1:0] control_interface_select_i,
	input wire [1:0] detect_config_strap_i,
	input wire standby_pin_pair_a_i,
	input wire standby_pin_pair_b_i,
	input wire [15:0] eq_index_o,
	input wire [2:0] dc_gain_o,
	input wire [3:0] term_50_o,
	input wire [3:0] rx_detected_o,
	input wire [3:0] standby_o
);
	logic [4:0] cnt;
	// Cycles since reset release
	always @(posedge clk_i)
		if (rst_i) cnt <= 5'h00;
		else if (cnt != 5'h1f) cnt <= cnt + 5'h01;
	function automatic logic [2:0] gain_of(input logic [1:0] g, input logic [1:0] s);
		if (g == 2'h3 && s == 2'h2) return 3'h0;
		if (g != 2'h2) return 3'h1;
		case (s)
			2'h0: return 3'h4;
			2'h1: return 3'h3;
			2'h3: return 3'h2;
			default: return 3'h1;
		endcase
	endfunction
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_pins_low;
		(!standby_pin_pair_a_i && !standby_pin_pair_b_i) [*4];
	endsequence
	property p_ack_next;
		s_req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack not a single cycle after request");
	property p_unmapped;
		s_req ##0 (!wb_we_i && wb_adr_i == 8'h40) |=> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_eq_strap;
		cnt == 5'h0f && control_interface_select_i == 2'h0 |-> eq_index_o == {4{eq_high_strap_i, eq_low_strap_i}};
	endproperty
	a_eq_strap: assert property (p_eq_strap) else $error("strap eq index wrong");
	property p_gain;
		cnt == 5'h0f |-> dc_gain_o == gain_of(gain_strap_i, output_swing_strap_i);
	endproperty
	a_gain: assert property (p_gain) else $error("dc gain wrong");
	property p_hold;
		cnt > 5'h0f && control_interface_select_i == 2'h0 |-> $stable(eq_index_o) && $stable(dc_gain_o);
	endproperty
	a_hold: assert property (p_hold) else $error("decoded straps changed");
	property p_bypass;
		(cnt > 5'h0f && detect_config_strap_i == 2'h3) ##0 s_pins_low |-> term_50_o == 4'hf;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass termination not 50 ohm");
	property p_stby_a;
		standby_pin_pair_a_i [*5] |-> standby_o[1:0] == 2'h3 && term_50_o[1:0] == 2'h0 && rx_detected_o[1:0] == 2'h0;
	endproperty
	a_stby_a: assert property (p_stby_a) else $error("pair a standby wrong");
	property p_stby_b;
		standby_pin_pair_b_i [*5] |-> standby_o[3:2] == 2'h3 && term_50_o[3:2] == 2'h0 && rx_detected_o[3:2] == 2'h0;
	endproperty
	a_stby_b: assert property (p_stby_b) else $error("pair b standby wrong");
	property p_det_term;
		cnt > 5'h0f && detect_config_strap_i != 2'h3 |-> term_50_o == rx_detected_o;
	endproperty
	a_det_term: assert property (p_det_term) else $error("termination does not follow detection");
endmodule
bind rdc_ctrl rdc_ctrl_chk chk_u (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.gain_strap_i(gain_strap_i),
	.output_swing_strap_i(output_swing_strap_i),
	.eq_high_strap_i(eq_high_strap_i),
	.eq_low_strap_i(eq_low_strap_i),
	.control_interface_select_i(control_interface_select_i),
	.detect_config_strap_i(detect_config_strap_i),
	.standby_pin_pair_a_i(standby_pin_pair_a_i),
	.standby_pin_pair_b_i(standby_pin_pair_b_i),
	.eq_index_o(eq_index_o),
	.dc_gain_o(dc_gain_o),
	.term_50_o(term_50_o),
	.rx_detected_o(rx_detected_o),
	.standby_o(standby_o)
);

/* File: rdc_far_rx.sv */
// Far-end receiver termination model
`timescale 1ns/1ps
module rdc_far_rx (
	input wire clk_i,
	input wire [3:0] attach_i,
	input wire [3:0] settle_i,
	output logic [3:0] rx_present_o = 4'h0
);
	logic [7:0] age = 8'h00;
	// Termination shows a settle time after attach
	always @(posedge clk_i) begin
		if (attach_i == 4'h0) age <= 8'h00;
		else if (age != 8'hff) age <= age + 8'h01;
		rx_present_o <= (age >= {4'h0, settle_i}) ? attach_i : 4'h0;
	end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the redriver control block
`timescale 1ns/1ps
`include "rdc_defs.vh"
module tb_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pa = 0, pb = 0, scl = 1, sda_m = 1;
	logic ack, soe, sdo;
	logic [31:0] wv;
	wire sda_bus = (soe ? sdo : 1'b1) & sda_m;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd, v;
	logic [1:0] gn = 2'h2, sw = 2'h2, hi = 2'h0, lo = 2'h0, sel = 2'h0, det = 2'h2;
	logic [3:0] mask = 4'h0, settle = 4'h0, pres, term, dtd, stby;
	logic [15:0] eq;
	logic [2:0] gain;
	logic [1:0] gt [5] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h2};
	logic [1:0] st [5] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h0};
	int bad_count = 0, tests_run = 0, cyc_n = 0, n;
	initial forever #10 clk_i = ~clk_i;
	rdc_far_rx far_u (.clk_i(clk_i), .attach_i(mask), .settle_i(settle), .rx_present_o(pres));
	rdc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .gain_strap_i(gn),
		.output_swing_strap_i(sw), .eq_high_strap_i(hi), .eq_low_strap_i(lo), .control_interface_select_i(sel),
		.detect_config_strap_i(det), .standby_pin_pair_a_i(pa), .standby_pin_pair_b_i(pb), .rx_present_i(pres),
		.scl_i(scl), .sda_i(sda_bus), .sda_o(sdo), .sda_oe_o(soe), .eq_index_o(eq), .dc_gain_o(gain),
		.term_50_o(term), .rx_detected_o(dtd), .standby_o(stby));
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 60000) begin
			bad_count++;
			final_report();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		v = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// Serial controller, about 380 kHz
	task i2c_start;
		sda_m <= 1'b0;
		tick(44);
		scl <= 1'b0;
		tick(44);
	endtask
	task i2c_stop;
		sda_m <= 1'b0;
		tick(44);
		scl <= 1'b1;
		tick(44);
		sda_m <= 1'b1;
		tick(44);
	endtask
	task i2c_byte(input logic [7:0] b, input logic a);
		for (int j = 7; j >= 0; j--) begin
			sda_m <= b[j];
			tick(44);
			scl <= 1'b1;
			tick(44);
			scl <= 1'b0;
			tick(44);
		end
		sda_m <= 1'b1;
		tick(44);
		scl <= 1'b1;
		tick(22);
		chk(sda_bus, !a);
		tick(22);
		scl <= 1'b0;
		tick(44);
	endtask
	task boot(input logic [1:0] g, s, h, l, c, d);
		@(posedge clk_i);
		{gn, sw, hi, lo, sel, det} <= {g, s, h, l, c, d};
		rst_i <= 1'b1;
		tick(12);
		rst_i <= 1'b0;
		tick(10);
	endtask
	function automatic logic [2:0] exp_gain(input logic [1:0] g, input logic [1:0] s);
		if (g == 2'h3 && s == 2'h2) return 3'h0;
		if (g != 2'h2) return 3'h1;
		return (s == 2'h0) ? 3'h4 : (s == 2'h1) ? 3'h3 : (s == 2'h3) ? 3'h2 : 3'h1;
	endfunction
	initial begin
		v = $urandom(21);
		for (int i = 0; i < 8; i++) begin
			n = (i % 3 == 0) ? 2 : (i % 3 == 1) ? 3 : 1;
			mask <= 4'($urandom);
			settle <= 4'($urandom_range(8));
			boot(i < 5 ? gt[i] : 2'($urandom), i < 5 ? st[i] : 2'($urandom), 2'($urandom), 2'($urandom), 2'h0,
				2'(i % 3));
			// After n-1 probes, one short of the confirmation count
			tick(n * `RDC_PROBE_CYC - 40);
			chk({dtd, term}, 8'h00);
			tick(800);
			chk(dtd, mask);
			chk(term, mask);
			chk(eq, {4{hi, lo}});
			chk(gain, exp_gain(gn, sw));
			pa <= 1'b1;
			tick(6);
			chk(stby, 4'h3);
			chk({dtd, term}, {mask[3:2], 2'h0, mask[3:2], 2'h0});
			pa <= 1'b0;
			tick(n * `RDC_PROBE_CYC + 300);
			chk({stby, dtd}, {4'h0, mask});
		end
		mask <= 4'hf;
		boot(2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h3);
		tick(1100);
		chk({dtd, term}, 8'h0f);
		pb <= 1'b1;
		tick(6);
		chk(term, 4'h3);
		pb <= 1'b0;
		mask <= 4'h0;
		boot(2'h2, 2'h2, 2'h1, 2'h2, 2'h3, 2'h2);
		wv = $urandom;
		wb(1'b1, `RDC_REG_EQ, wv);
		tick(2);
		chk(eq, wv[15:0]);
		wb(1'b0, `RDC_REG_EQ, 32'h0);
		chk(v, {16'h0, wv[15:0]});
		wb(1'b0, 8'h40, 32'hffffffff);
		chk(v, 32'h0);
		wb(1'b0, `RDC_REG_STRAP, 32'h0);
		chk(v, {19'h0, 1'b1, det, sel, hi, lo, sw, gn});
		// Neighbouring address must not be answered
		i2c_start();
		i2c_byte({7'(`RDC_TGT_ADDR_BASE + 4 * hi + lo + 1), 1'b0}, 1'b0);
		i2c_stop();
		wv = $urandom;
		i2c_start();
		i2c_byte({7'(`RDC_TGT_ADDR_BASE + 4 * hi + lo), 1'b0}, 1'b1);
		i2c_byte(8'h02, 1'b1);
		i2c_byte({4'h0, wv[3:0]}, 1'b1);
		i2c_byte({4'h0, wv[7:4]}, 1'b1);
		i2c_stop();
		chk(eq[15:8], wv[7:0]);
		// Pin release restarts nothing in target mode
		mask <= 4'hf;
		pa <= 1'b1;
		pb <= 1'b1;
		tick(6);
		pa <= 1'b0;
		pb <= 1'b0;
		tick(600);
		chk(dtd, 4'h0);
		wb(1'b1, `RDC_REG_CTRL, 32'h1);
		tick(800);
		chk(dtd, 4'hf);
		wb(1'b0, `RDC_REG_STATUS, 32'h0);
		chk(v & 32'h20f, 32'h20f);
		final_report();
	end
endmodule
